/* File: common/tsc_map.vh */
// Register map, field positions and reset values of the touch capture block
`ifndef TSC_MAP_VH
`define TSC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TSC_OFS_CTRL 16'hA130
`define TSC_OFS_ANALOG 16'hA131
`define TSC_OFS_FILTER 16'hA132
`define TSC_OFS_THR0 16'hA133
`define TSC_OFS_THR1 16'hA134
`define TSC_OFS_THR2 16'hA135
`define TSC_OFS_RELOAD0 16'hA140
`define TSC_OFS_VALUE0 16'hA144
`define TSC_OFS_FAST0 16'hA148
`define TSC_OFS_SLOW0 16'hA14C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define TSC_CTRL_ENABLE 7
`define TSC_CTRL_MODE 6
`define TSC_CTRL_CLKSEL_HI 5
`define TSC_CTRL_CLKSEL_LO 4
`define TSC_CTRL_AUTO 3
`define TSC_CTRL_IRQ_EN 2
`define TSC_CTRL_IRQ_FLAG 1
`define TSC_CTRL_START 0

// ----------------------------------------
// Analog register fields
// ----------------------------------------
`define TSC_ANA_COMPARATOR_SPEED_SELECT 7
`define TSC_ANA_DITHER 6
`define TSC_ANA_MULT 4
`define TSC_ANA_STEP_HI 3
`define TSC_ANA_STEP_LO 0

// ----------------------------------------
// Filter register fields
// ----------------------------------------
`define TSC_FLT_SLOW_HI 7
`define TSC_FLT_SLOW_LO 4
`define TSC_FLT_FAST_HI 3
`define TSC_FLT_FAST_LO 0
`define TSC_SLOW_MAX_CODE 4'h4
`define TSC_SLOW_BASE_SHIFT 3'h3
`define TSC_FAST_MAX_CODE 4'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TSC_RST_BYTE 8'h00
`define TSC_RST_WORD 24'h000000
`define TSC_PRBS_SEED 8'hFF

`endif

/* File: src/tsc_prbs.v */
// Pseudo-random bit source of period 255 for current dithering
`timescale 1ns/1ps

`include "tsc_map.vh"

module tsc_prbs (
   input wire i_clk,
   input wire i_rst,
   input wire i_step,
   output wire o_bit
);

   reg [7:0] lfsr_q;
   wire fb;

   // ----------------------------------------
   // Maximal length 8-bit shift register
   // ----------------------------------------
   assign fb = lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3];
   assign o_bit = lfsr_q[7];

   always @(posedge i_clk) begin
      if (i_rst) begin
         lfsr_q <= `TSC_PRBS_SEED;
      end else if (i_step) begin
         lfsr_q <= {lfsr_q[6:0], fb};
      end
   end

endmodule

/* File: src/tsc_mavg.v */
// Moving-average update step, shared by the slow and fast filters
`timescale 1ns/1ps

`include "tsc_map.vh"

module tsc_mavg #(
   parameter W = 24,
   parameter IS_SLOW = 1
) (
   input wire [W-1:0] i_value,
   input wire [W-1:0] i_avg,
   input wire [3:0] i_setting,
   output reg [W-1:0] o_avg
);

   reg [2:0] shift;
   reg pass;
   reg [W+7:0] acc;

   // ----------------------------------------
   // (value + (N-1)*avg) / N, N a power of two
   // ----------------------------------------
   always @* begin
      shift = 3'h0;
      pass = 1'b1;
      acc = {(W+8){1'b0}};
      if (IS_SLOW != 0) begin
         if (i_setting != 4'h0 && i_setting <= `TSC_SLOW_MAX_CODE) begin
            shift = i_setting[2:0] + `TSC_SLOW_BASE_SHIFT;
            pass = 1'b0;
         end
      end else begin
         if (i_setting != 4'h0 && i_setting <= `TSC_FAST_MAX_CODE) begin
            shift = i_setting[2:0];
            pass = 1'b0;
         end
      end
      acc = ({8'h00, i_avg} << shift) - {8'h00, i_avg} + {8'h00, i_value};
      acc = acc >> shift;
      if (pass) begin
         o_avg = i_value;
      end else begin
         o_avg = acc[W-1:0];
      end
   end

endmodule

/* File: src/tsc_top.v */
// Capture control, register file and filters of the touch capture block
`timescale 1ns/1ps

`include "tsc_map.vh"

// Notes on behaviour
// - Clock select codes 0,1 pick fast oscillator; 2,3 pick slow oscillator.
// - Busy bit is high exactly while a capture runs.
// - Writing one to start with the enable bit also set begins a capture.
// - Auto off: one capture, then idle.
// - Auto on: captures repeat until a touch is detected.
// - Writing zero to start aborts a running capture at once.
// - Speed bit drives comparator speed only; it does not set the current scale.
// - Dither on: 255-bit sequence picks single or double current per cycle.
// - Multiplier bit asks the current source for five times current.
// - Four-bit step code goes to the current source, 0.125uA per step.
// - Slow filter: copy for 0, N of 16..128 for codes 1..4.
// - Fast filter: copy for 0, N of 2,4,8 for codes 1..3.
// - Start clears counter, loads timer; expiry captures and updates averages.
// - Mode 0: sensor clocks timer; mode 1: internal clock times.
// - Auto mode wakes when fast average beats slow by the threshold.
module tsc_top #(
   parameter W = 24
) (
   input wire I_CLK_SYS,
   input wire I_SYS_RST,
   input wire [15:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [7:0] O_RDATA,
   input wire I_SENSE_OSC,
   input wire I_FAST_OSC,
   input wire I_SLOW_OSC,
   output reg O_SENSE_EN,
   output reg O_CLK_SEL_SLOW,
   output reg O_COMP_COMPARATOR_SPEED_SELECT,
   output reg O_CUR_DOUBLE,
   output reg O_CUR_MULT5,
   output reg [3:0] O_CUR_STEP,
   output reg O_BUSY,
   output reg O_WAKE,
   output reg O_IRQ
);

   // ----------------------------------------
   // Byte access helpers
   // ----------------------------------------
   function [W-1:0] byte_put;
      input [W-1:0] old;
      input [1:0] idx;
      input [7:0] data;
      begin
         byte_put = old;
         case (idx)
            2'h0: byte_put[7:0] = data;
            2'h1: byte_put[15:8] = data;
            2'h2: byte_put[23:16] = data;
            default: byte_put = old;
         endcase
      end
   endfunction

   function [7:0] byte_get;
      input [W-1:0] word;
      input [1:0] idx;
      begin
         case (idx)
            2'h0: byte_get = word[7:0];
            2'h1: byte_get = word[15:8];
            2'h2: byte_get = word[23:16];
            default: byte_get = 8'h00;
         endcase
      end
   endfunction

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [7:0] ctrl_q;
   reg [7:0] analog_q;
   reg [7:0] filter_q;
   reg [W-1:0] thr_q;
   reg [W-1:0] reload_q;
   reg [W-1:0] value_q;
   reg [W-1:0] fast_q;
   reg [W-1:0] slow_q;
   reg [W-1:0] timer_q;
   reg [W-1:0] count_q;
   reg state_q;
   reg flag_q;
   reg sense_prev_q;
   reg fast_prev_q;
   reg slow_prev_q;

   reg [7:0] ctrl_d;
   reg [W-1:0] fast_d;
   reg [W-1:0] slow_d;
   reg [W-1:0] value_d;
   reg [W-1:0] timer_d;
   reg [W-1:0] count_d;
   reg state_d;
   reg flag_d;
   reg wake_d;

   wire [W-1:0] fast_upd;
   wire [W-1:0] slow_upd;
   wire [W-1:0] capture;
   wire prbs_bit;
   wire sense_tick;
   wire int_tick;
   wire timer_tick;
   wire count_tick;
   wire expire;
   wire wr_ctrl;
   wire start_cmd;
   wire abort_cmd;
   wire detect;
   wire [1:0] idx;

   // ----------------------------------------
   // Clock sources and pairing
   // ----------------------------------------
   assign sense_tick = I_SENSE_OSC & ~sense_prev_q;
   assign int_tick = ctrl_q[`TSC_CTRL_CLKSEL_HI] ?
      (I_SLOW_OSC & ~slow_prev_q) : (I_FAST_OSC & ~fast_prev_q);
   assign timer_tick = ctrl_q[`TSC_CTRL_MODE] ? int_tick : sense_tick;
   assign count_tick = ctrl_q[`TSC_CTRL_MODE] ? sense_tick : int_tick;

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   assign idx = I_ADDR[1:0];
   assign wr_ctrl = I_WR && (I_ADDR == `TSC_OFS_CTRL);
   assign start_cmd = wr_ctrl && I_WDATA[`TSC_CTRL_START] &&
      I_WDATA[`TSC_CTRL_ENABLE];
   assign abort_cmd = wr_ctrl && !start_cmd;
   assign expire = (state_q == ST_RUN) && timer_tick &&
      (timer_q <= {{(W-1){1'b0}}, 1'b1});
   assign capture = count_tick ? count_q + {{(W-1){1'b0}}, 1'b1} : count_q;

   // ----------------------------------------
   // Filters and dither source
   // ----------------------------------------
   tsc_mavg #(.W(W), .IS_SLOW(1)) u_slow (
      .i_value(capture),
      .i_avg(slow_q),
      .i_setting(filter_q[`TSC_FLT_SLOW_HI:`TSC_FLT_SLOW_LO]),
      .o_avg(slow_upd)
   );

   tsc_mavg #(.W(W), .IS_SLOW(0)) u_fast (
      .i_value(capture),
      .i_avg(fast_q),
      .i_setting(filter_q[`TSC_FLT_FAST_HI:`TSC_FLT_FAST_LO]),
      .o_avg(fast_upd)
   );

   tsc_prbs u_prbs (
      .i_clk(I_CLK_SYS),
      .i_rst(I_SYS_RST),
      .i_step(sense_tick),
      .o_bit(prbs_bit)
   );

   assign detect = ({1'b0, fast_upd} > ({1'b0, slow_upd} + {1'b0, thr_q}));

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always @* begin
      ctrl_d = ctrl_q;
      fast_d = fast_q;
      slow_d = slow_q;
      value_d = value_q;
      timer_d = timer_q;
      count_d = count_q;
      state_d = state_q;
      flag_d = flag_q;
      wake_d = 1'b0;
      if (wr_ctrl) begin
         ctrl_d = I_WDATA;
         if (!I_WDATA[`TSC_CTRL_IRQ_FLAG]) begin
            flag_d = 1'b0;
         end
      end
      if (I_WR && I_ADDR[15:2] == `TSC_OFS_FAST0 >> 2) begin
         fast_d = byte_put(fast_q, idx, I_WDATA);
      end
      if (I_WR && I_ADDR[15:2] == `TSC_OFS_SLOW0 >> 2) begin
         slow_d = byte_put(slow_q, idx, I_WDATA);
      end
      case (state_q)
         ST_IDLE: begin
            if (start_cmd) begin
               count_d = {W{1'b0}};
               timer_d = reload_q;
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (start_cmd) begin
               count_d = {W{1'b0}};
               timer_d = reload_q;
            end else if (abort_cmd) begin
               state_d = ST_IDLE;
            end else if (expire) begin
               value_d = capture;
               fast_d = fast_upd;
               slow_d = slow_upd;
               count_d = {W{1'b0}};
               timer_d = reload_q;
               if (!ctrl_q[`TSC_CTRL_AUTO]) begin
                  state_d = ST_IDLE;
                  flag_d = 1'b1;
               end else if (detect) begin
                  state_d = ST_IDLE;
                  flag_d = 1'b1;
                  wake_d = 1'b1;
               end
            end else begin
               count_d = capture;
               if (timer_tick) begin
                  timer_d = timer_q - {{(W-1){1'b0}}, 1'b1};
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always @(posedge I_CLK_SYS) begin
      if (I_SYS_RST) begin
         ctrl_q <= `TSC_RST_BYTE;
         analog_q <= `TSC_RST_BYTE;
         filter_q <= `TSC_RST_BYTE;
         thr_q <= `TSC_RST_WORD;
         reload_q <= `TSC_RST_WORD;
         value_q <= `TSC_RST_WORD;
         fast_q <= `TSC_RST_WORD;
         slow_q <= `TSC_RST_WORD;
         timer_q <= `TSC_RST_WORD;
         count_q <= `TSC_RST_WORD;
         state_q <= ST_IDLE;
         flag_q <= 1'b0;
         sense_prev_q <= 1'b0;
         fast_prev_q <= 1'b0;
         slow_prev_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         fast_q <= fast_d;
         slow_q <= slow_d;
         value_q <= value_d;
         timer_q <= timer_d;
         count_q <= count_d;
         state_q <= state_d;
         flag_q <= flag_d;
         sense_prev_q <= I_SENSE_OSC;
         fast_prev_q <= I_FAST_OSC;
         slow_prev_q <= I_SLOW_OSC;
         if (I_WR && I_ADDR == `TSC_OFS_ANALOG) begin
            analog_q <= I_WDATA;
         end
         if (I_WR && I_ADDR == `TSC_OFS_FILTER) begin
            filter_q <= I_WDATA;
         end
         if (I_WR && I_ADDR >= `TSC_OFS_THR0 &&
            I_ADDR <= `TSC_OFS_THR2) begin
            thr_q <= byte_put(thr_q, I_ADDR[1:0] - 2'h3, I_WDATA);
         end
         if (I_WR && I_ADDR[15:2] == `TSC_OFS_RELOAD0 >> 2) begin
            reload_q <= byte_put(reload_q, idx, I_WDATA);
         end
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always @(posedge I_CLK_SYS) begin
      if (I_SYS_RST) begin
         O_SENSE_EN <= 1'b0;
         O_CLK_SEL_SLOW <= 1'b0;
         O_COMP_COMPARATOR_SPEED_SELECT <= 1'b0;
         O_CUR_DOUBLE <= 1'b0;
         O_CUR_MULT5 <= 1'b0;
         O_CUR_STEP <= 4'h0;
         O_BUSY <= 1'b0;
         O_WAKE <= 1'b0;
         O_IRQ <= 1'b0;
      end else begin
         O_SENSE_EN <= ctrl_d[`TSC_CTRL_ENABLE];
         O_CLK_SEL_SLOW <= ctrl_d[`TSC_CTRL_CLKSEL_HI];
         O_COMP_COMPARATOR_SPEED_SELECT <= analog_q[`TSC_ANA_COMPARATOR_SPEED_SELECT];
         O_CUR_DOUBLE <= analog_q[`TSC_ANA_DITHER] & prbs_bit;
         O_CUR_MULT5 <= analog_q[`TSC_ANA_MULT];
         O_CUR_STEP <= analog_q[`TSC_ANA_STEP_HI:`TSC_ANA_STEP_LO];
         O_BUSY <= (state_d == ST_RUN);
         O_WAKE <= wake_d;
         O_IRQ <= flag_d & ctrl_d[`TSC_CTRL_IRQ_EN];
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always @(posedge I_CLK_SYS) begin
      if (I_SYS_RST || !I_RD) begin
         O_RDATA <= 8'h00;
      end else begin
         case (I_ADDR)
            `TSC_OFS_CTRL: O_RDATA <= {ctrl_q[7:2], flag_q,
               state_q == ST_RUN};
            `TSC_OFS_ANALOG: O_RDATA <= {analog_q[7:6], 1'b0, analog_q[4:0]};
            `TSC_OFS_FILTER: O_RDATA <= filter_q;
            `TSC_OFS_THR0: O_RDATA <= thr_q[7:0];
            `TSC_OFS_THR1: O_RDATA <= thr_q[15:8];
            `TSC_OFS_THR2: O_RDATA <= thr_q[23:16];
            default: begin
               if (I_ADDR[15:2] == `TSC_OFS_RELOAD0 >> 2) begin
                  O_RDATA <= byte_get(reload_q, idx);
               end else if (I_ADDR[15:2] == `TSC_OFS_VALUE0 >> 2) begin
                  O_RDATA <= byte_get(value_q, idx);
               end else if (I_ADDR[15:2] == `TSC_OFS_FAST0 >> 2) begin
                  O_RDATA <= byte_get(fast_q, idx);
               end else if (I_ADDR[15:2] == `TSC_OFS_SLOW0 >> 2) begin
                  O_RDATA <= byte_get(slow_q, idx);
               end else begin
                  O_RDATA <= 8'h00;
               end
            end
         endcase
      end
   end

endmodule

/* File: verification/tsc_props.sv */
// Port checks of the touch capture block
`timescale 1ns/1ps

`include "tsc_map.vh"

module tsc_props (
   input wire I_CLK_SYS,
   input wire I_SYS_RST,
   input wire [15:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_WR,
   input wire O_SENSE_EN,
   input wire O_CLK_SEL_SLOW,
   input wire O_COMP_COMPARATOR_SPEED_SELECT,
   input wire O_CUR_DOUBLE,
   input wire O_CUR_MULT5,
   input wire [3:0] O_CUR_STEP,
   input wire O_BUSY,
   input wire O_WAKE,
   input wire O_IRQ
);
   // ---------
   // Shadow of settings
   // ---------
   wire wr_ctrl = I_WR && I_ADDR == `TSC_OFS_CTRL;
   wire wr_ana = I_WR && I_ADDR == `TSC_OFS_ANALOG;
   wire start = wr_ctrl && I_WDATA[7] && I_WDATA[0];
   reg [7:0] ctrl_q;
   reg [7:0] ana_q;
   reg [1:0] cage_q;
   reg [1:0] aage_q;
   always @(posedge I_CLK_SYS) begin
      if (I_SYS_RST) begin
         ctrl_q <= 8'h00;
         ana_q <= 8'h00;
         cage_q <= 2'h3;
         aage_q <= 2'h3;
      end else begin
         if (wr_ctrl)
            ctrl_q <= I_WDATA;
         if (wr_ana)
            ana_q <= I_WDATA;
         cage_q <= wr_ctrl ? 2'h0 : cage_q + {1'b0, cage_q != 2'h3};
         aage_q <= wr_ana ? 2'h0 : aage_q + {1'b0, aage_q != 2'h3};
      end
   end
   // ---------
   // Assertions
   // ---------
   default clocking @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_SYS_RST);
   a_start_busy: assert property (start |=> O_BUSY)
      else $error("busy missing after start");
   a_abort_idle: assert property (O_BUSY && wr_ctrl && !start |=> !O_BUSY)
      else $error("abort did not stop capture");
   a_idle_hold: assert property (!O_BUSY && !start |=> !O_BUSY)
      else $error("busy rose without start");
   a_irq_gate: assert property (O_IRQ |-> ctrl_q[2] || $past(ctrl_q[2]))
      else $error("irq while disabled");
   a_wake_pulse: assert property (O_WAKE |=> !O_WAKE)
      else $error("wake longer than one cycle");
   a_wake_auto: assert property (O_WAKE |-> ctrl_q[3] || $past(ctrl_q[3]))
      else $error("wake outside auto mode");
   a_wake_stop: assert property (O_WAKE |-> ##[0:1] !O_BUSY)
      else $error("auto capture kept running");
   a_clk_map: assert property (cage_q >= 2'h2 |->
      {O_SENSE_EN, O_CLK_SEL_SLOW} == {ctrl_q[7], ctrl_q[5]})
      else $error("clock select output wrong");
   a_analog_map: assert property (aage_q >= 2'h2 |->
      {O_COMP_COMPARATOR_SPEED_SELECT, O_CUR_MULT5, O_CUR_STEP} ==
      {ana_q[7], ana_q[4], ana_q[3:0]})
      else $error("analog outputs wrong");
   a_no_dither: assert property (aage_q >= 2'h2 && !ana_q[6] |-> !O_CUR_DOUBLE)
      else $error("double current without dither");
   c_start: cover property (start);
   c_abort: cover property (O_BUSY && wr_ctrl && !start);
   c_wake: cover property (O_WAKE);
endmodule

/* File: verification/tsc_osc_model.sv */
// Sensing oscillator standing for the key capacitance
`timescale 1ns/1ps

module tsc_osc_model (
   input wire i_clk,
   input wire i_en,
   input wire i_hold,
   input wire i_comparator_speed_select,
   output reg o_osc
);
   reg [1:0] cnt_q;
   initial begin
      o_osc = 1'b0;
      cnt_q = 2'h0;
   end
   always @(posedge i_clk) begin
      if (!i_en || i_hold) begin
         o_osc <= 1'b0;
         cnt_q <= 2'h0;
      end else if (cnt_q == (i_comparator_speed_select ? 2'h1 : 2'h3)) begin
         o_osc <= ~o_osc;
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end
endmodule

/* File: verification/test_tsc_top.sv */
// Self-checking bench of the touch capture block
`timescale 1ns/1ps

module test_tsc_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] adr = 16'h0000;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic run = 1'b0;
   logic fosc = 1'b0;
   logic sosc = 1'b0;
   logic hold = 1'b1;
   logic [7:0] b;
   logic [23:0] v, fa, sa;
   int k;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int n_wake = 0;
   logic [15:0] k_addr [4] = '{16'hA130, 16'hA131, 16'hA132, 16'hA137};
   wire osc, en, slow, hs, dbl, m5, busy, wake, irq;
   wire [7:0] rdata;
   wire [3:0] step;
   tsc_top u_tsc_top (
      .I_CLK_SYS(clk), .I_SYS_RST(rst), .I_ADDR(adr), .I_WDATA(wd),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SENSE_OSC(osc),
      .I_FAST_OSC(fosc), .I_SLOW_OSC(sosc), .O_SENSE_EN(en),
      .O_CLK_SEL_SLOW(slow), .O_COMP_COMPARATOR_SPEED_SELECT(hs), .O_CUR_DOUBLE(dbl),
      .O_CUR_MULT5(m5), .O_CUR_STEP(step), .O_BUSY(busy), .O_WAKE(wake),
      .O_IRQ(irq)
   );
   tsc_osc_model u_tsc_osc_model (
      .i_clk(clk), .i_en(en), .i_hold(hold), .i_comparator_speed_select(hs), .o_osc(osc)
   );
   // ---------
   // Clock, monitors and tasks
   // ---------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      sosc <= ~sosc;
      if (run)
         fosc <= ~fosc;
      if (wake === 1'b1)
         n_wake++;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   task automatic stop_test;
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [23:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd8(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      adr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic wr24(input logic [15:0] a, input logic [23:0] d);
      for (int i = 0; i < 3; i++)
         wr8(a + 16'(i), d[8*i +: 8]);
   endtask
   task automatic rd24(input logic [15:0] a, output logic [23:0] d);
      for (int i = 0; i < 3; i++)
         rd8(a + 16'(i), d[8*i +: 8]);
   endtask
   task automatic pulse(input int n);
      @(posedge clk);
      run <= 1'b1;
      repeat (2 * n) @(posedge clk);
      run <= 1'b0;
      repeat (4) tick();
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 300 && busy !== 1'b0; i++)
         tick();
      chk("idle", busy, 1'b0);
   endtask
   function automatic logic [23:0] mavg(input int c, input int top,
         input int sh, input logic [23:0] x, input logic [23:0] a);
      int n;
      n = 1 << (c + sh);
      if (c == 0 || c > top)
         return x;
      return 24'((x + (n - 1) * a) / n);
   endfunction
   // ---------
   // Scenarios
   // ---------
   initial begin
      void'($urandom(45));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wr8(16'hA137, 8'hFF);
      foreach (k_addr[i]) begin
         rd8(k_addr[i], b);
         chk("reset", b, 8'h00);
      end
      for (int c = 0; c < 4; c++) begin
         wr8(16'hA130, 8'(c << 4));
         repeat (2) tick();
         chk("clksel", slow, c[1]);
         rd8(16'hA130, b);
         chk("ctrl", b, 8'(c << 4));
      end
      for (int i = 0; i < 8; i++) begin
         b = (i == 0) ? 8'hFF : 8'($urandom);
         wr8(16'hA131, b);
         repeat (2) tick();
         chk("analog", {hs, m5, step}, {b[7], b[4], b[3:0]});
         rd8(16'hA131, v[7:0]);
         chk("analog_rb", v[7:0] & 8'hDF, b & 8'hDF);
      end
      wr8(16'hA131, 8'h00);
      wr24(16'hA140, 24'h000003);
      for (int i = 0; i < 16; i++) begin
         fa = 24'($urandom_range(65535));
         sa = 24'($urandom_range(65535));
         k = $urandom_range(20, 1);
         wr8(16'hA132, {i[3:0], 4'(15 - i)});
         wr24(16'hA148, fa);
         wr24(16'hA14C, sa);
         wr8(16'hA130, 8'h85);
         tick();
         chk("busy", busy, 1'b1);
         pulse(k);
         chk("busy", busy, 1'b1);
         hold <= 1'b0;
         wait_idle();
         hold <= 1'b1;
         rd24(16'hA144, v);
         chk("value", v, 24'(k));
         rd24(16'hA148, v);
         chk("fast", v, mavg(15 - i, 3, 0, 24'(k), fa));
         rd24(16'hA14C, v);
         chk("slow", v, mavg(i, 4, 3, 24'(k), sa));
         chk("irq", irq, 1'b1);
         wr8(16'hA130, 8'h04);
         tick();
         chk("irq", irq, 1'b0);
      end
      wr8(16'hA130, 8'hC1);
      pulse(2);
      chk("busy", busy, 1'b1);
      pulse(1);
      wait_idle();
      rd24(16'hA144, v);
      chk("value", v, 24'h000000);
      wr8(16'hA130, 8'hE1);
      tick();
      chk("busy", busy, 1'b1);
      wait_idle();
      wr8(16'hA130, 8'h81);
      pulse(2);
      wr8(16'hA130, 8'h80);
      tick();
      chk("busy", busy, 1'b0);
      rd8(16'hA130, b);
      chk("ctrl", b, 8'h80);
      tick();
      chk("rdata", rdata, 8'h00);
      wr8(16'hA132, 8'h00);
      hold <= 1'b0;
      wr8(16'hA130, 8'h8D);
      repeat (120) tick();
      chk("busy", busy, 1'b1);
      chk("wake", 24'(n_wake), 24'h000000);
      chk("irq", irq, 1'b0);
      wr24(16'hA133, 24'h000040);
      wr8(16'hA132, 8'h40);
      run <= 1'b1;
      repeat (100) tick();
      chk("wake", 24'(n_wake), 24'h000000);
      rd24(16'hA133, v);
      chk("thr", v, 24'h000040);
      wr24(16'hA133, 24'h000000);
      for (int i = 0; i < 400 && n_wake == 0; i++)
         tick();
      run <= 1'b0;
      repeat (2) tick();
      chk("busy", busy, 1'b0);
      chk("wake", 24'(n_wake), 24'h000001);
      chk("irq", irq, 1'b1);
      wr8(16'hA130, 8'h80);
      wr8(16'hA131, 8'h40);
      k = 0;
      repeat (400) begin
         tick();
         k += (dbl === 1'b1);
      end
      chk("dither", 24'(k > 0 && k < 400), 24'h000001);
      stop_test();
   end
endmodule

bind tsc_top tsc_props u_tsc_props (
   .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .O_SENSE_EN(O_SENSE_EN),
   .O_CLK_SEL_SLOW(O_CLK_SEL_SLOW), .O_COMP_COMPARATOR_SPEED_SELECT(O_COMP_COMPARATOR_SPEED_SELECT),
   .O_CUR_DOUBLE(O_CUR_DOUBLE), .O_CUR_MULT5(O_CUR_MULT5),
   .O_CUR_STEP(O_CUR_STEP), .O_BUSY(O_BUSY), .O_WAKE(O_WAKE), .O_IRQ(O_IRQ)
);
